/* hdl/tap_controller.sv */
// Boundary-scan test access port controller with boundary register
`timescale 1ns/1ps
module tap_controller (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	input wire logic [tap_pkg::TAP_BSR_LEN-1:0] pin_in,
	input wire logic [tap_pkg::TAP_BSR_LEN-1:0] core_data_in,
	output logic [tap_pkg::TAP_BSR_LEN-1:0] pin_data_out,
	output logic test_mode_out
);
	import tap_pkg::*;

	// ****************************************
	// Test clock domain reset
	// ****************************************
	// Asserts at once, releases on the test clock
	logic tck_rst_meta;
	logic tck_rst;

	always_ff @(posedge tck_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tck_rst_meta <= 1'h1;
			tck_rst <= 1'h1;
		end else begin
			tck_rst_meta <= 1'h0;
			tck_rst <= tck_rst_meta;
		end
	end

	// ****************************************
	// State machine
	// ****************************************
	tap_state_t state;
	tap_state_t next_state;

	function automatic tap_state_t step(input tap_state_t s, input logic m);
		case (s)
			TAP_TLR: step = m ? TAP_TLR : TAP_RTI;
			TAP_RTI: step = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: step = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: step = m ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: step = m ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: step = m ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: step = m ? TAP_TLR : TAP_CAP_IR;
			TAP_CAP_IR: step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: step = m ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: step = m ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: step = m ? TAP_SEL_DR : TAP_RTI;
			default: step = TAP_TLR;
		endcase
	endfunction

	always_comb begin
		next_state = step(state, tms_in);
	end

	// Async reset gives the reset state with no test clock edge
	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			state <= TAP_TLR;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Pin sampling into the test clock domain
	// ****************************************
	logic [TAP_BSR_LEN-1:0] pin_meta;
	logic [TAP_BSR_LEN-1:0] pin_sync;

	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			pin_meta <= TAP_BSR_RESET;
			pin_sync <= TAP_BSR_RESET;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************
	// Instruction register
	// ****************************************
	logic [TAP_IR_W-1:0] ir_shift;
	logic [TAP_IR_W-1:0] ir_cur;
	logic bsr_sel;
	logic id_sel;
	logic ext_cur;

	function automatic logic is_extest(input logic [TAP_IR_W-1:0] c);
		is_extest = (c == TAP_IR_EXTEST);
	endfunction

	always_comb begin
		bsr_sel = is_extest(ir_cur) || (ir_cur == TAP_IR_SAMPLE);
		id_sel = (ir_cur == TAP_IR_IDCODE);
	end

	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			ir_shift <= TAP_IR_CAPTURE;
		end else if (state == TAP_CAP_IR) begin
			ir_shift <= TAP_IR_CAPTURE;
		end else if (state == TAP_SHIFT_IR) begin
			ir_shift <= {tdi_in, ir_shift[TAP_IR_W-1:1]};
		end
	end

	// Falling edge keeps the parallel output still while shifting
	always_ff @(negedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			ir_cur <= TAP_IR_IDCODE;
		end else if (state == TAP_TLR) begin
			ir_cur <= TAP_IR_IDCODE;
		end else if (state == TAP_UPD_IR) begin
			ir_cur <= ir_shift;
		end
	end

	// Registered test flag, so the crossing never sees a decode glitch
	always_ff @(negedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			ext_cur <= 1'h0;
		end else if (state == TAP_TLR) begin
			ext_cur <= 1'h0;
		end else if (state == TAP_UPD_IR) begin
			ext_cur <= is_extest(ir_shift);
		end
	end

	// ****************************************
	// Data registers
	// ****************************************
	logic bypass_reg;
	logic [TAP_ID_W-1:0] id_shift;
	logic [TAP_BSR_LEN-1:0] bsr_shift;
	logic [TAP_BSR_LEN-1:0] bsr_par;
	logic par_tgl;
	logic dr_out;

	// Bypass has no parallel input, so capture leaves it alone
	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			bypass_reg <= 1'h0;
		end else if (state == TAP_SHIFT_DR && !bsr_sel && !id_sel) begin
			bypass_reg <= tdi_in;
		end
	end

	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			id_shift <= TAP_IDCODE_VALUE;
		end else if (id_sel && state == TAP_CAP_DR) begin
			id_shift <= TAP_IDCODE_VALUE;
		end else if (id_sel && state == TAP_SHIFT_DR) begin
			id_shift <= {tdi_in, id_shift[TAP_ID_W-1:1]};
		end
	end

	always_ff @(posedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			bsr_shift <= TAP_BSR_RESET;
		end else if (bsr_sel && state == TAP_CAP_DR) begin
			bsr_shift <= pin_sync;
		end else if (bsr_sel && state == TAP_SHIFT_DR) begin
			bsr_shift <= {tdi_in, bsr_shift[TAP_BSR_LEN-1:1]};
		end
	end

	always_ff @(negedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			bsr_par <= TAP_BSR_RESET;
			par_tgl <= 1'h0;
		end else if (bsr_sel && state == TAP_UPD_DR) begin
			bsr_par <= bsr_shift;
			par_tgl <= ~par_tgl;
		end
	end

	always_comb begin
		if (bsr_sel) begin
			dr_out = bsr_shift[0];
		end else if (id_sel) begin
			dr_out = id_shift[0];
		end else begin
			dr_out = bypass_reg;
		end
	end

	// ****************************************
	// Serial output
	// ****************************************
	// Launched on the falling edge for a half period of hold at the tester
	always_ff @(negedge tck_in or posedge tck_rst) begin
		if (tck_rst) begin
			tdo_out <= TAP_TDO_RESET;
			tdo_oe_out <= 1'h0;
		end else begin
			tdo_out <= (state == TAP_SHIFT_IR) ? ir_shift[0] : dr_out;
			tdo_oe_out <= (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);
		end
	end

	// ****************************************
	// System clock side
	// ****************************************
	// Toggle announces a new latched word; the word is held for several
	// test clocks after each load, so it has settled when the toggle arrives
	logic ext_meta;
	logic ext_sync;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic [TAP_BSR_LEN-1:0] par_cap;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ext_meta <= 1'h0;
			ext_sync <= 1'h0;
			tgl_meta <= 1'h0;
			tgl_sync <= 1'h0;
			tgl_seen <= 1'h0;
		end else begin
			ext_meta <= ext_cur;
			ext_sync <= ext_meta;
			tgl_meta <= par_tgl;
			tgl_sync <= tgl_meta;
			tgl_seen <= tgl_sync;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			par_cap <= TAP_BSR_RESET;
		end else if (tgl_sync != tgl_seen) begin
			par_cap <= bsr_par;
		end
	end

	// Normal operation unless extest is the current instruction
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_data_out <= TAP_BSR_RESET;
			test_mode_out <= 1'h0;
		end else begin
			pin_data_out <= ext_sync ? par_cap : core_data_in;
			test_mode_out <= ext_sync;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_tms_high5;
		tms_in [*5];
	endsequence

	sequence s_in_seldr;
		state == TAP_SEL_DR;
	endsequence

	a_reset_five: assert property (@(posedge tck_in) disable iff (tck_rst)
		s_tms_high5 |=> (state == TAP_TLR))
		else $error("five high mode selects did not reach reset state");

	a_reset_exit: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_TLR && !tms_in) |=> (state == TAP_RTI))
		else $error("reset state did not move to idle");

	a_idle_hold: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_RTI && !tms_in) |=> (state == TAP_RTI) && $stable(ir_cur)
		&& $stable(bsr_shift))
		else $error("idle did not hold");

	a_seldr_branch: assert property (@(posedge tck_in) disable iff (tck_rst)
		s_in_seldr |=> (state == ($past(tms_in) ? TAP_SEL_IR : TAP_CAP_DR)))
		else $error("data select branch wrong");

	a_capture_bsr: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_CAP_DR && bsr_sel) |=> (bsr_shift == $past(pin_sync)))
		else $error("boundary capture missed pins");

	a_exit1_dr: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_EXIT1_DR) |=> (state == ($past(tms_in) ? TAP_UPD_DR : TAP_PAUSE_DR)))
		else $error("data exit one branch wrong");

	a_pause_hold: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_PAUSE_DR && !tms_in) |=> (state == TAP_PAUSE_DR)
		&& $stable(bsr_shift) && $stable(id_shift))
		else $error("data pause did not hold");

	a_bsr_latch: assert property (@(posedge tck_in) disable iff (tck_rst)
		$changed(bsr_par) |-> (state == TAP_UPD_DR) && bsr_sel)
		else $error("boundary output changed outside data update");

	a_ir_capture: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_CAP_IR) |=> (ir_shift == TAP_IR_CAPTURE))
		else $error("instruction capture pattern wrong");

	a_ir_shift: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_SHIFT_IR) |=> (ir_shift == {$past(tdi_in), $past(ir_shift[2:1])}))
		else $error("instruction shift wrong");

	a_ir_update: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_UPD_IR) |=> (ir_cur == $past(ir_shift)))
		else $error("instruction not latched in update");

	a_update_exit: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_UPD_DR || state == TAP_UPD_IR)
		|=> (state == ($past(tms_in) ? TAP_SEL_DR : TAP_RTI)))
		else $error("update exit wrong");

	a_selir_branch: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_SEL_IR) |=> (state == ($past(tms_in) ? TAP_TLR : TAP_CAP_IR)))
		else $error("instruction select branch wrong");

	a_capdr_branch: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_CAP_DR) |=> (state == ($past(tms_in) ? TAP_EXIT1_DR : TAP_SHIFT_DR)))
		else $error("data capture branch wrong");

	a_bsr_shift: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_SHIFT_DR && bsr_sel)
		|=> (bsr_shift == {$past(tdi_in), $past(bsr_shift[TAP_BSR_LEN-1:1])}))
		else $error("boundary shift wrong");

	a_exit2_dr: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_EXIT2_DR) |=> (state == ($past(tms_in) ? TAP_UPD_DR : TAP_SHIFT_DR)))
		else $error("data exit two branch wrong");

	a_exit1_ir: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_EXIT1_IR) |=> (state == ($past(tms_in) ? TAP_UPD_IR : TAP_PAUSE_IR)))
		else $error("instruction exit one branch wrong");

	a_tlr_ident: assert property (@(posedge tck_in) disable iff (tck_rst)
		(state == TAP_TLR) |=> (ir_cur == TAP_IR_IDCODE) && !ext_cur)
		else $error("reset state did not restore identity instruction");

	a_tdo_enable: assert property (@(posedge tck_in) disable iff (tck_rst)
		tdo_oe_out == ((state == TAP_SHIFT_DR) || (state == TAP_SHIFT_IR)))
		else $error("serial output enable wrong");

endmodule

/* inc/tap_pkg.sv */
// Constants and types of the boundary-scan test access port controller
package tap_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int TAP_IR_W = 3;
	localparam int TAP_BSR_LEN = 8;
	localparam int TAP_ID_W = 32;

	// ****************************************
	// Instruction codes and fixed values
	// ****************************************
	localparam logic [TAP_IR_W-1:0] TAP_IR_CAPTURE = 3'h4;
	localparam logic [TAP_IR_W-1:0] TAP_IR_EXTEST = 3'h0;
	localparam logic [TAP_IR_W-1:0] TAP_IR_SAMPLE = 3'h1;
	localparam logic [TAP_IR_W-1:0] TAP_IR_IDCODE = 3'h2;
	localparam logic [TAP_IR_W-1:0] TAP_IR_BYPASS = 3'h7;
	// Arbitrary identity value, bit 0 set as scan convention wants
	localparam logic [TAP_ID_W-1:0] TAP_IDCODE_VALUE = 32'h0A5C_3001;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic TAP_TDO_RESET = 1'h0;
	localparam logic [TAP_BSR_LEN-1:0] TAP_BSR_RESET = 8'h00;

	// ****************************************
	// Controller states
	// ****************************************
	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR,
		TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
		TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
		TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} tap_state_t;

endpackage

/* testbench/tap_controller_tb_top.sv */
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
module tap_controller_tb_top;
	import tap_pkg::*;
	logic clk_in = 1'h0;
	logic sys_rst_in = 1'h1;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic [TAP_BSR_LEN-1:0] pin_in = 8'h00;
	logic [TAP_BSR_LEN-1:0] core_data_in = 8'h00;
	logic [TAP_BSR_LEN-1:0] pin_data_out;
	logic test_mode_out;
	logic [31:0] rd;
	int n_errors = 0;
	int n_tests = 0;

	always #25 clk_in = ~clk_in;

	tap_host_model host_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

	tap_controller dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .tck_in(tck),
		.tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.pin_in(pin_in), .core_data_in(core_data_in), .pin_data_out(pin_data_out),
		.test_mode_out(test_mode_out));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic set_in(input logic [7:0] pins, input logic [7:0] core);
		@(posedge clk_in);
		pin_in <= pins;
		core_data_in <= core;
	endtask

	// Crossed outputs lag by a few system clocks, so wait bounded
	task automatic settle(input logic [7:0] pd, input logic tm);
		int i;
		i = 0;
		while (i < 20 && (pin_data_out !== pd || test_mode_out !== tm)) begin
			@(posedge clk_in);
			#1;
			i++;
		end
		#1;
		chk({23'h0, test_mode_out, pin_data_out}, {23'h0, tm, pd});
		if (i == 20) begin
			print_verdict();
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		set_in(8'h00, 8'h96);
		settle(8'h96, 1'h0);
		chk({31'h0, tdo_oe}, 32'h0);
	endtask

	task automatic t_idcode();
		host_u.walk(8'h00, 4);
		host_u.scan(1'h0, 32, 0, 32'h0, rd);
		chk(rd, TAP_IDCODE_VALUE);
		chk({31'h0, tdo_oe}, 32'h0);
	endtask

	task automatic t_extest();
		set_in(8'hA5, 8'h96);
		host_u.scan(1'h1, 3, 0, {29'h0, TAP_IR_EXTEST}, rd);
		chk(rd, {29'h0, TAP_IR_CAPTURE});
		host_u.scan(1'h0, 8, 3, 32'h3C, rd);
		chk(rd, 32'hA5);
		settle(8'h3C, 1'h1);
		host_u.scan(1'h1, 3, 2, {29'h0, TAP_IR_EXTEST}, rd);
		chk(rd, {29'h0, TAP_IR_CAPTURE});
		settle(8'h3C, 1'h1);
	endtask

	task automatic t_sample();
		host_u.scan(1'h1, 3, 0, {29'h0, TAP_IR_SAMPLE}, rd);
		set_in(8'h5A, 8'h69);
		host_u.scan(1'h0, 8, 0, 32'hC3, rd);
		chk(rd, 32'h5A);
		settle(8'h69, 1'h0);
	endtask

	// Preloaded value shows under the test instruction, then five highs reset
	task automatic t_tlr();
		host_u.scan(1'h1, 3, 0, {29'h0, TAP_IR_EXTEST}, rd);
		settle(8'hC3, 1'h1);
		host_u.walk(8'h01, 3);
		host_u.walk(8'h1F, 5);
		host_u.walk(8'h00, 1);
		settle(8'h69, 1'h0);
		host_u.scan(1'h0, 32, 0, 32'h0, rd);
		chk(rd, TAP_IDCODE_VALUE);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		host_u.walk(8'h7F, 8);
		t_reset();
		t_idcode();
		t_extest();
		t_sample();
		t_tlr();
		print_verdict();
	end
endmodule

/* testbench/tap_host_model.sv */
// Behavioural boundary-scan test controller on the far side of the port
`timescale 1ns/1ps
module tap_host_model (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	// ****************************************
	// Idle levels
	// ****************************************
	// Test clock stands still low between frames
	initial begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h0;
	end

	// ****************************************
	// Bit level
	// ****************************************
	// One 80 ns period; serial out taken at the rising edge
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#40;
		tdo = tdo_in;
		tck_out = 1'h1;
		#40;
		tck_out = 1'h0;
	endtask

	// Mode select pattern, first bit lowest; serial in toggles as it is unused
	task automatic walk(input logic [7:0] seq, input int n);
		logic t;
		for (int i = 0; i < n; i++) begin
			step(seq[i], ~tdi_out, t);
		end
	endtask

	// ****************************************
	// Scan level
	// ****************************************
	// Idle to idle; split above zero and below n detours through pause after that bit
	task automatic scan(input logic ir, input int n, input int split,
		input logic [31:0] din, output logic [31:0] dout);
		logic t;
		dout = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 2 : 1);
		walk(8'h00, 2);
		for (int i = 0; i < n; i++) begin
			step((i == n - 1) || (i == split - 1), din[i], t);
			dout[i] = t;
			if (i == split - 1 && i != n - 1) begin
				walk(8'h04, 4);
			end
		end
		walk(8'h01, 2);
	endtask
endmodule
